// ===== core/host_port_device.sv
// Device end: host port slave with performance counter readout
// Summary of operation
// - Host drives direction low for writes
// - Host presents 15-bit target address
// - Decoder drives chip select low meanwhile
// - Host places write byte before strobe
// - Host starts cycle with write strobe low
// - Select, direction, strobe low open input path
// - Acknowledge stays low after strobe falls
// - Host holds strobe until acknowledge high
// - Acknowledge rises after some clock periods
// - Acknowledge changes only on host clock rise
// - Register updates wait for transmit clock
// - System keeps transmit clock running always; the testbench stops it in its stalled transmit clock test
// - Counters are 16 bits, cleared when read
// - Host reads counter as two bytes
// - Either byte may be read first
// - First byte read clears whole counter
// - Unread byte copied to holding register
// - Second byte comes from holding register
// - Readout covers all seven error counters
`timescale 1ns/100ps
`default_nettype none
module host_port_device (
   input  wire logic                              mclk_in,
   input  wire logic                              rst_n_in,
   host_port_if.device                            bus,
   input  wire logic                              transmit_input_clock_in,
   input  wire logic [host_port_pkg::NUM_CNT-1:0] count_event_in,
   output logic                                   wr_valid_out,
   output logic [host_port_pkg::ADDR_W-1:0]       wr_addr_out,
   output logic [host_port_pkg::DATA_W-1:0]       wr_data_out
);
   import host_port_pkg::*;

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic [5:0]  pin_s1;
      logic [5:0]  pin_s2;
      logic [14:0] addr_s1;
      logic [14:0] addr_s2;
      logic [7:0]  data_s1;
      logic [7:0]  data_s2;
      logic        hclk_prev;
      logic        txclk_prev;
      dev_state_t  state;
      logic        is_write;
      logic [14:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic        drive;
      logic        ack;
      logic [7:0]  hold;
      logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
      logic        wr_valid;
   } dev_regs_t;

   dev_regs_t st_r;
   dev_regs_t st_nxt;

   // Counter index from a byte address; MSB at even, LSB at odd
   function automatic logic cnt_hit(input logic [14:0] a);
      logic [14:0] off;
      off = a - CNT_BASE_ADDR;
      return (a >= CNT_BASE_ADDR) && (off < 15'(2 * NUM_CNT));
   endfunction

   function automatic logic [2:0] cnt_idx(input logic [14:0] a);
      logic [14:0] off;
      off = a - CNT_BASE_ADDR;
      return off[3:1];
   endfunction

   logic hclk_rise;
   logic tx_rise;
   logic cs_act;
   logic wr_act;
   logic rd_act;
   logic [2:0] idx;

   //------------------------------------------------------------
   // Decode of synchronised pins
   //------------------------------------------------------------
   // Pin order: hclk, tx clock, select, write, read, direction
   assign hclk_rise = st_r.pin_s2[0] & ~st_r.hclk_prev;
   assign tx_rise   = st_r.pin_s2[1] & ~st_r.txclk_prev;
   assign cs_act    = ~st_r.pin_s2[2];
   // A strobe with the wrong direction opens no cycle
   assign wr_act    = cs_act & ~st_r.pin_s2[3] & ~st_r.pin_s2[5];
   assign rd_act    = cs_act & ~st_r.pin_s2[4] &  st_r.pin_s2[5];
   assign idx       = cnt_idx(st_r.addr);

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      logic ws_low;
      logic rs_low;
      ws_low = 1'b0;
      rs_low = 1'b0;
      st_nxt = st_r;
      // Pins come from the host clock domain, and the tx clock from its own
      st_nxt.pin_s1  = {bus.rw, bus.read_strobe_n, bus.write_strobe_n,
                        bus.cs_n, transmit_input_clock_in, bus.host_clk};
      st_nxt.pin_s2  = st_r.pin_s1;
      st_nxt.addr_s1 = bus.addr;
      st_nxt.addr_s2 = st_r.addr_s1;
      st_nxt.data_s1 = bus.data_bus;
      st_nxt.data_s2 = st_r.data_s1;
      st_nxt.hclk_prev  = st_r.pin_s2[0];
      st_nxt.txclk_prev = st_r.pin_s2[1];
      st_nxt.wr_valid   = 1'b0;
      ws_low = ~st_r.pin_s2[3];
      rs_low = ~st_r.pin_s2[4];

      // Counting; a read clear in the same cycle keeps the event
      // Saturating, so a long gap between reads never wraps
      for (int i = 0; i < NUM_CNT; i++) begin
         if (count_event_in[i] && st_r.cnt[i] != 16'hffff) begin
            st_nxt.cnt[i] = st_r.cnt[i] + 16'h0001;
         end
      end

      unique case (st_r.state)
         DEV_IDLE: begin
            // Direction is sampled in the same edge as the strobes
            if (hclk_rise && wr_act) begin
               st_nxt.is_write = 1'b1;
               st_nxt.addr     = st_r.addr_s2;
               st_nxt.wdata    = st_r.data_s2;
               st_nxt.state    = DEV_WAIT_TX;
            end else if (hclk_rise && rd_act) begin
               st_nxt.is_write = 1'b0;
               st_nxt.addr     = st_r.addr_s2;
               st_nxt.state    = DEV_WAIT_TX;
            end
         end
         DEV_WAIT_TX: begin
            // Nothing completes without the transmit clock
            if (tx_rise) begin
               st_nxt.state = DEV_READY;
               if (st_r.is_write) begin
                  st_nxt.wr_valid = 1'b1;
               end else if (cnt_hit(st_r.addr)) begin
                  // Either byte first; other byte saved
                  if (st_r.addr[0]) begin
                     st_nxt.rdata = st_r.cnt[idx][7:0];
                     st_nxt.hold  = st_r.cnt[idx][15:8];
                  end else begin
                     st_nxt.rdata = st_r.cnt[idx][15:8];
                     st_nxt.hold  = st_r.cnt[idx][7:0];
                  end
                  st_nxt.cnt[idx] = count_event_in[idx] ?
                                    16'h0001 : 16'h0000;
               end else if (st_r.addr == HOLD_ADDR) begin
                  st_nxt.rdata = st_r.hold;
               end else begin
                  st_nxt.rdata = UNMAPPED_RD;
               end
               // Read data stands on the bus until acknowledge falls
               st_nxt.drive = ~st_r.is_write;
            end
         end
         DEV_READY: begin
            if (hclk_rise) begin
               st_nxt.ack   = 1'b1;
               st_nxt.state = DEV_ACKED;
            end
         end
         DEV_ACKED: begin
            // Host keeps strobe low until it sees acknowledge
            if (hclk_rise && !(cs_act && (ws_low || rs_low))) begin
               st_nxt.ack   = 1'b0;
               st_nxt.drive = 1'b0;
               st_nxt.state = DEV_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r       <= '0;
         st_r.state <= DEV_IDLE;
         // Pins start at idle levels so no cycle opens at release
         st_r.pin_s1 <= {4'hf, 2'h0};
         st_r.pin_s2 <= {4'hf, 2'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   // Every output comes straight from a flop
   assign bus.dev_d                = st_r.rdata;
   assign bus.dev_d_oe_n           = ~st_r.drive;
   assign bus.transfer_acknowledge = st_r.ack;
   assign wr_valid_out             = st_r.wr_valid;
   assign wr_addr_out              = st_r.addr;
   assign wr_data_out              = st_r.wdata;
endmodule
`default_nettype wire

// ===== core/host_port_master.sv
// Host end: APB-controlled processor driving the host port
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module host_port_master (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   host_port_if.host        bus,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out
);
   import host_port_pkg::*;

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  div;
      logic        hclk;
      logic        ack_s1;
      logic        ack_s2;
      logic [7:0]  d_s1;
      logic [7:0]  d_s2;
      hst_state_t  state;
      logic [14:0] addr_reg;
      logic [7:0]  wdata_reg;
      logic        go;
      logic        rd_req;
      logic        done;
      logic [7:0]  rdata;
      logic        cs_n;
      logic        rw;
      logic        ws_n;
      logic        rs_n;
      logic [14:0] addr;
      logic [7:0]  d;
      logic        d_oe_n;
   } hst_regs_t;

   hst_regs_t st_r;
   hst_regs_t st_nxt;

   logic acc;
   logic rise;
   logic fall;
   logic hit;

   assign acc  = psel_in & penable_in;
   // Only the first four words decode; anything above reads zero
   assign hit  = (paddr_in[31:4] == 28'h000_0000);
   // Outputs move on the falling half so the device sees setup
   assign rise = (st_r.div == HALF_LAST) & ~st_r.hclk;
   assign fall = (st_r.div == HALF_LAST) &  st_r.hclk;

   always_comb begin
      st_nxt = st_r;
      st_nxt.div    = (st_r.div == HALF_LAST) ? 2'h0 : st_r.div + 2'h1;
      st_nxt.hclk   = (st_r.div == HALF_LAST) ? ~st_r.hclk : st_r.hclk;
      st_nxt.ack_s1 = bus.transfer_acknowledge;
      st_nxt.ack_s2 = st_r.ack_s1;
      st_nxt.d_s1   = bus.data_bus;
      st_nxt.d_s2   = st_r.d_s1;

      // Orders written while busy are dropped
      if (acc && pwrite_in && hit && st_r.state == HST_IDLE && !st_r.go) begin
         unique case (paddr_in[3:0])
            OFS_ADDR:  st_nxt.addr_reg  = pwdata_in[14:0];
            OFS_WDATA: st_nxt.wdata_reg = pwdata_in[7:0];
            OFS_CTRL: begin
               st_nxt.go     = pwdata_in[CTRL_GO_BIT];
               st_nxt.rd_req = pwdata_in[CTRL_READ_BIT];
               if (pwdata_in[CTRL_GO_BIT]) begin
                  st_nxt.done = 1'b0;
               end
            end
            default: ;
         endcase
      end

      unique case (st_r.state)
         HST_IDLE: begin
            if (st_r.go && fall) begin
               st_nxt.go     = 1'b0;
               st_nxt.rw     = st_r.rd_req;
               st_nxt.addr   = st_r.addr_reg;
               st_nxt.cs_n   = 1'b0;
               st_nxt.d      = st_r.wdata_reg;
               st_nxt.d_oe_n = st_r.rd_req;
               st_nxt.state  = HST_SETUP;
            end
         end
         HST_SETUP: begin
            if (fall) begin
               st_nxt.ws_n  = st_r.rd_req;
               st_nxt.rs_n  = ~st_r.rd_req;
               st_nxt.state = HST_WAIT_ACK;
            end
         end
         HST_WAIT_ACK: begin
            // Strobe stays low until acknowledge is seen
            if (rise && st_r.ack_s2) begin
               st_nxt.rdata = st_r.d_s2;
               st_nxt.state = HST_RELEASE;
            end
         end
         HST_RELEASE: begin
            if (fall) begin
               st_nxt.ws_n   = 1'b1;
               st_nxt.rs_n   = 1'b1;
               st_nxt.cs_n   = 1'b1;
               st_nxt.rw     = 1'b1;
               st_nxt.d_oe_n = 1'b1;
               st_nxt.state  = HST_WAIT_LOW;
            end
         end
         HST_WAIT_LOW: begin
            if (rise && !st_r.ack_s2) begin
               st_nxt.done  = 1'b1;
               st_nxt.state = HST_IDLE;
            end
         end
         default: st_nxt.state = HST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r        <= '0;
         st_r.state  <= HST_IDLE;
         st_r.cs_n   <= 1'b1;
         st_r.rw     <= 1'b1;
         st_r.ws_n   <= 1'b1;
         st_r.rs_n   <= 1'b1;
         st_r.d_oe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   //------------------------------------------------------------
   // APB read mux and pins
   //------------------------------------------------------------
   always_comb begin
      prdata_out = 32'h0000_0000;
      if (hit) begin
         unique case (paddr_in[3:0])
            OFS_ADDR:  prdata_out = {17'h0_0000, st_r.addr_reg};
            OFS_WDATA: prdata_out = {24'h00_0000, st_r.wdata_reg};
            OFS_CTRL:  prdata_out = {30'h0000_0000, st_r.rd_req, st_r.go};
            OFS_STATUS: begin
               prdata_out[STAT_BUSY_BIT] = st_r.go | (st_r.state != HST_IDLE);
               prdata_out[STAT_DONE_BIT] = st_r.done;
               prdata_out[STAT_RDATA_LSB +: 8] = st_r.rdata;
            end
            default: ;
         endcase
      end
   end

   assign pready_out         = 1'b1;
   assign pslverr_out        = 1'b0;
   assign bus.host_clk       = st_r.hclk;
   assign bus.cs_n           = st_r.cs_n;
   assign bus.rw             = st_r.rw;
   assign bus.write_strobe_n = st_r.ws_n;
   assign bus.read_strobe_n  = st_r.rs_n;
   assign bus.addr           = st_r.addr;
   assign bus.host_d         = st_r.d;
   assign bus.host_d_oe_n    = st_r.d_oe_n;
endmodule
`default_nettype wire

// ===== shared/host_port_if.sv
// Pin-level carrier between host processor end and device end
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
   import host_port_pkg::*;
   logic              host_clk;
   logic              cs_n;
   logic              rw;
   logic              write_strobe_n;
   logic              read_strobe_n;
   logic [14:0]       addr;
   logic [7:0]        host_d;
   logic              host_d_oe_n;
   logic [7:0]        dev_d;
   logic              dev_d_oe_n;
   logic              transfer_acknowledge;
   logic [7:0]        data_bus;

   // Idle bus floats high through its pull-ups
   assign data_bus = !host_d_oe_n ? host_d :
                     (!dev_d_oe_n ? dev_d : 8'hff);

   modport host (
      output host_clk, cs_n, rw, write_strobe_n, read_strobe_n, addr,
      output host_d, host_d_oe_n,
      input  transfer_acknowledge, data_bus
   );
   modport device (
      input  host_clk, cs_n, rw, write_strobe_n, read_strobe_n, addr,
      input  data_bus,
      output dev_d, dev_d_oe_n, transfer_acknowledge
   );
endinterface
`default_nettype wire

// ===== shared/host_port_pkg.sv
// Shared constants and types for the synchronous host port
package host_port_pkg;
   //------------------------------------------------------------
   // Widths and timing
   //------------------------------------------------------------
   localparam int ADDR_W          = 15;
   localparam int DATA_W          = 8;
   localparam int CNT_W           = 16;
   localparam int NUM_CNT         = 7;
   localparam int MCLK_PERIOD_NS  = 40;
   localparam int HCLK_PERIOD_NS  = 320;
   localparam int HCLK_HALF_CYC   = HCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   localparam logic [1:0] HALF_LAST = 2'(HCLK_HALF_CYC - 1);

   //------------------------------------------------------------
   // Device map
   //------------------------------------------------------------
   localparam logic [14:0] HOLD_ADDR     = 15'h116c;
   localparam logic [14:0] CNT_BASE_ADDR = 15'h1100;
   localparam logic [7:0]  UNMAPPED_RD   = 8'h00;

   //------------------------------------------------------------
   // Controller registers (APB byte offsets)
   //------------------------------------------------------------
   localparam logic [3:0] OFS_ADDR   = 4'h0;
   localparam logic [3:0] OFS_WDATA  = 4'h4;
   localparam logic [3:0] OFS_CTRL   = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;
   localparam int CTRL_GO_BIT    = 0;
   localparam int CTRL_READ_BIT  = 1;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;
   localparam int STAT_RDATA_LSB = 8;

   typedef enum logic [1:0] {
      DEV_IDLE,
      DEV_WAIT_TX,
      DEV_READY,
      DEV_ACKED
   } dev_state_t;

   typedef enum logic [2:0] {
      HST_IDLE,
      HST_SETUP,
      HST_WAIT_ACK,
      HST_RELEASE,
      HST_WAIT_LOW
   } hst_state_t;
endpackage

// ===== verif/host_port_props.sv
// Concurrent checks on the host port pins between the two ends
`timescale 1ns/100ps
`default_nettype none
module host_port_props (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic host_clk,
   input wire logic cs_n,
   input wire logic rw,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic dev_d_oe_n,
   input wire logic transfer_acknowledge
);
   //------------------------------------------------------------
   // Host clock rise tracker
   //------------------------------------------------------------
   // Device sees host_clk through a synchroniser, so allow a few cycles
   logic       hclk_q;
   logic [3:0] since_rise;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hclk_q     <= 1'b0;
         since_rise <= 4'hf;
      end else begin
         hclk_q <= host_clk;
         if (host_clk && !hclk_q)
            since_rise <= 4'h0;
         else if (since_rise != 4'hf)
            since_rise <= since_rise + 4'h1;
      end
   end
   //------------------------------------------------------------
   // Properties
   //------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   AST_ACK_ON_HCLK_RISE: assert property (
      $changed(transfer_acknowledge) |-> since_rise <= 4'h5)
      else $error("Acknowledge moved away from a host clock rise");
   AST_ACK_LOW_AT_STROBE: assert property (
      $fell(write_strobe_n) |-> !transfer_acknowledge [*4])
      else $error("Acknowledge high too early after strobe");
   AST_ACK_WITHIN_BOUND: assert property (
      $fell(write_strobe_n) && !rw && !cs_n |-> ##[1:1000] transfer_acknowledge)
      else $error("Write never acknowledged");
   AST_ACK_NEEDS_CYCLE: assert property (
      $rose(transfer_acknowledge) |-> !cs_n && !(write_strobe_n && read_strobe_n))
      else $error("Acknowledge rose with no open cycle");
   AST_ACK_STANDS: assert property (
      transfer_acknowledge && !cs_n && !write_strobe_n |=> transfer_acknowledge)
      else $error("Acknowledge dropped while strobe held");
   AST_ACK_FALL_RELEASED: assert property (
      $fell(transfer_acknowledge) |-> cs_n || (write_strobe_n && read_strobe_n))
      else $error("Acknowledge fell before release");
   AST_WRITE_INPUT_PATH: assert property (
      !cs_n && !rw && !write_strobe_n |-> dev_d_oe_n)
      else $error("Device drives bus in a write cycle");
   AST_READ_DRIVES: assert property (
      transfer_acknowledge && !cs_n && rw && !read_strobe_n |-> !dev_d_oe_n)
      else $error("Device silent in acknowledged read");
   AST_IDLE_RELEASED: assert property (
      cs_n && !transfer_acknowledge && !$past(transfer_acknowledge)
      |-> dev_d_oe_n)
      else $error("Device drives bus while unselected");
endmodule
`default_nettype wire

// ===== verif/sync_host_write_and_counter_readout_tb_top.sv
// Testbench top joining host and device ends over the host port
`timescale 1ns/100ps
`default_nettype none
module sync_host_write_and_counter_readout_tb_top;
   import host_port_pkg::*;
   logic        mclk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        tx_clk = 1'b0;
   logic        tx_run = 1'b1;
   logic [6:0]  cnt_ev = 7'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        wr_valid;
   logic [14:0] wr_addr;
   logic [7:0]  wr_data;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          wr_seen = 0;
   logic [14:0] last_addr;
   logic [7:0]  last_data;
   logic        ws_q = 1'b1;
   logic        seen_ack = 1'b0;
   logic        rel_ack = 1'b0;
   logic        st_rw = 1'b1;
   logic        st_cs = 1'b1;
   logic [14:0] st_addr;
   logic [7:0]  st_data;

   host_port_if hp ();
   host_port_master host_port_master_i (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .bus(hp), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out());
   host_port_device host_port_device_i (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .bus(hp), .transmit_input_clock_in(tx_clk),
      .count_event_in(cnt_ev), .wr_valid_out(wr_valid),
      .wr_addr_out(wr_addr), .wr_data_out(wr_data));
   host_port_props host_port_props_i (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .host_clk(hp.host_clk), .cs_n(hp.cs_n),
      .rw(hp.rw), .write_strobe_n(hp.write_strobe_n),
      .read_strobe_n(hp.read_strobe_n), .dev_d_oe_n(hp.dev_d_oe_n),
      .transfer_acknowledge(hp.transfer_acknowledge));

   always #20 mclk_in = ~mclk_in;
   // Odd start offset keeps tx clock unrelated in phase
   initial begin
      #7;
      forever begin
         #160;
         if (tx_run) tx_clk = ~tx_clk;
      end
   end
   //------------------------------------------------------------
   // Pin and write monitor
   //------------------------------------------------------------
   always @(negedge mclk_in) begin
      if (wr_valid === 1'b1) begin
         wr_seen++;
         last_addr = wr_addr;
         last_data = wr_data;
      end
      if (ws_q === 1'b1 && hp.write_strobe_n === 1'b0) begin
         st_rw = hp.rw;
         st_cs = hp.cs_n;
         st_addr = hp.addr;
         st_data = hp.data_bus;
         seen_ack = 1'b0;
      end
      if (hp.transfer_acknowledge === 1'b1) seen_ack = 1'b1;
      if (ws_q === 1'b0 && hp.write_strobe_n === 1'b1) rel_ack = seen_ack;
      ws_q = hp.write_strobe_n;
   end
   //------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------
   task automatic final_report();
      $display("Checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic timeout();
      error_cnt++;
      $display("Error at %0t: wait ran out", $time);
      final_report();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_in);
      penable <= 1'b1;
      n = 0;
      // Request stands until the edge that samples pready high
      do begin
         @(posedge mclk_in);
         n++;
         if (n > 50) timeout();
      end while (pready !== 1'b1);
      // Taken at that same edge, before the design's flops update
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic dev_start(input logic rd, input logic [14:0] a,
                            input logic [7:0] d);
      logic [31:0] s;
      apb(1'b1, 32'(OFS_ADDR), 32'(a), s);
      apb(1'b1, 32'(OFS_WDATA), 32'(d), s);
      apb(1'b1, 32'(OFS_CTRL), rd ? 32'h3 : 32'h1, s);
   endtask
   task automatic dev_wait(output logic [7:0] q);
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         apb(1'b0, 32'(OFS_STATUS), 32'h0, s);
         n++;
         if (n > 400) timeout();
      end while (!(s[STAT_BUSY_BIT] === 1'b0 && s[STAT_DONE_BIT] === 1'b1));
      q = s[STAT_RDATA_LSB +: 8];
   endtask
   task automatic dev_op(input logic rd, input logic [14:0] a,
                         output logic [7:0] q);
      dev_start(rd, a, 8'h00);
      dev_wait(q);
   endtask
   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      logic [7:0]  q;
      logic [31:0] s;
      logic [14:0] a;
      logic [15:0] e;
      logic        lf;
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         a = k ? 15'h7fff : 15'h0001;
         dev_start(1'b0, a, k ? 8'ha5 : 8'h5a);
         dev_wait(q);
         chk(32'(wr_seen), 32'(k + 1));
         chk(last_addr, a);
         chk(last_data, k ? 8'ha5 : 8'h5a);
         chk(st_rw, 1'b0);
         chk(st_cs, 1'b0);
         chk(st_addr, a);
         chk(st_data, k ? 8'ha5 : 8'h5a);
         chk(rel_ack, 1'b1);
      end
      $display("Test back-to-back writes done");
      // Write parked until the tx clock runs again
      tx_run = 1'b0;
      dev_start(1'b0, 15'h0123, 8'h3c);
      repeat (300) @(posedge mclk_in);
      chk(32'(wr_seen), 32'd2);
      apb(1'b0, 32'(OFS_STATUS), 32'h0, s);
      chk(s[STAT_BUSY_BIT], 1'b1);
      tx_run = 1'b1;
      dev_wait(q);
      chk(32'(wr_seen), 32'd3);
      chk(last_data, 8'h3c);
      $display("Test stalled transmit clock done");
      for (int k = 0; k < 400; k++) begin
         @(posedge mclk_in);
         for (int i = 0; i < NUM_CNT; i++) cnt_ev[i] <= (k < 258 + 17 * i);
      end
      for (int i = 0; i < NUM_CNT; i++) begin
         a = CNT_BASE_ADDR + 15'(2 * i);
         e = 16'(258 + 17 * i);
         lf = i[0];
         dev_op(1'b1, a + 15'(lf), q);
         chk(q, lf ? e[7:0] : e[15:8]);
         dev_op(1'b1, HOLD_ADDR, q);
         chk(q, lf ? e[15:8] : e[7:0]);
         dev_op(1'b1, HOLD_ADDR, q);
         chk(q, lf ? e[15:8] : e[7:0]);
         dev_op(1'b1, a + 15'(!lf), q);
         chk(q, 8'h00);
         dev_op(1'b1, HOLD_ADDR, q);
         chk(q, 8'h00);
      end
      $display("Test counter readout done");
      dev_op(1'b1, 15'h0005, q);
      chk(q, UNMAPPED_RD);
      apb(1'b0, 32'h0000_0010, 32'h0, s);
      chk(s, 32'h0);
      $display("Test unmapped reads done");
      final_report();
   end
endmodule
`default_nettype wire
